// ===== verilog/pic_pkg.sv
package pic_pkg;
    // ****************
    // Address map
    // ****************
    localparam logic [31:0] BASE_A = 32'hff00c000;
    localparam logic [31:0] BASE_B = 32'hff010000;
    localparam int DEC_LSB = 8;
    localparam logic [7:0] OFF_OWN_SET = 8'h00;
    localparam logic [7:0] OFF_OWN_CLR = 8'h04;
    localparam logic [7:0] OFF_OWN_ST = 8'h08;
    localparam logic [7:0] OFF_DRV_SET = 8'h10;
    localparam logic [7:0] OFF_DRV_CLR = 8'h14;
    localparam logic [7:0] OFF_DRV_ST = 8'h18;
    localparam logic [7:0] OFF_VAL_SET = 8'h30;
    localparam logic [7:0] OFF_VAL_CLR = 8'h34;
    localparam logic [7:0] OFF_VAL_ST = 8'h38;
    localparam logic [7:0] OFF_PIN = 8'h3c;
    localparam logic [7:0] OFF_IRQ_SET = 8'h40;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h44;
    localparam logic [7:0] OFF_IRQ_ST = 8'h48;
    localparam logic [7:0] OFF_CHG_ST = 8'h4c;
    // ****************
    // Line layout, index 0 is A, 1 is B
    // ****************
    localparam logic [1:0][31:0] DEF_MASK = {32'h000003ff, 32'h00081fff};
    localparam logic [1:0][31:0] PER_MASK = {32'h000001ef, 32'h00081f0f};
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {WS_IDLE = 2'h0, WS_EXEC = 2'h1, WS_RESP = 2'h3} pic_wst_e;
    typedef enum logic {RS_IDLE = 1'h0, RS_RESP = 1'h1} pic_rst_e;
endpackage

// ===== verilog/pic_pin_mux.sv
`timescale 1ns/1ps
module pic_pin_mux
    import pic_pkg::*;
#(
    parameter logic [31:0] DEF = 32'h0,
    parameter logic [31:0] PER = 32'h0
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [31:0] own, // Controller ownership
    input wire logic [31:0] drv, // Stored driver enables
    input wire logic [31:0] oVal, // Stored output values
    input wire logic [31:0] pinIn, // Pin levels
    input wire logic [31:0] perOut, // Peripheral output values
    input wire logic [31:0] perOe, // Peripheral driver enables
    output logic [31:0] pinOut, // Pin output value
    output logic [31:0] pinOe, // Pin driver enable
    output logic [31:0] perIn // Level seen by peripherals
);
    logic [31:0] pinOut_r, pinOut_nxt, pinOe_r, pinOe_nxt, perIn_r, perIn_nxt;

    always_comb begin
        // Stored drive and value only reach the pin on owned lines
        pinOut_nxt = ((own & oVal) | (~own & perOut & PER)) & DEF;
        pinOe_nxt = ((own & drv) | (~own & perOe & PER)) & DEF;
        perIn_nxt = ~own & pinIn & PER;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pinOut_r <= RST_ZERO;
            pinOe_r <= RST_ZERO;
            perIn_r <= RST_ZERO;
        end else begin
            pinOut_r <= pinOut_nxt;
            pinOe_r <= pinOe_nxt;
            perIn_r <= perIn_nxt;
        end
    end

    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;
    assign perIn = perIn_r;
endmodule

// ===== verilog/pic_chg_det.sv
`timescale 1ns/1ps
module pic_chg_det
    import pic_pkg::*;
#(
    parameter logic [31:0] DEF = 32'h0
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [31:0] own, // Controller ownership
    input wire logic [31:0] drv, // Stored driver enables
    input wire logic [31:0] oVal, // Stored output values
    input wire logic [31:0] pinIn, // Pin levels
    input wire logic rdClr, // Status read this cycle
    output logic [31:0] evt, // Level change this cycle
    output logic [31:0] status // Accumulated changes
);
    logic [31:0] seen, prev_r, prev_nxt, st_r, st_nxt;
    logic armed_r, armed_nxt;

    always_comb begin
        // Owned driven lines watch the driven value, the rest the pin
        seen = ((own & drv & oVal) | (~(own & drv) & pinIn)) & DEF;
        // No compare until a real previous level exists
        evt = armed_r ? (seen ^ prev_r) : RST_ZERO;
        prev_nxt = seen;
        armed_nxt = 1'b1;
        st_nxt = (rdClr ? RST_ZERO : st_r) | evt;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev_r <= RST_ZERO;
            armed_r <= 1'b0;
            st_r <= RST_ZERO;
        end else begin
            prev_r <= prev_nxt;
            armed_r <= armed_nxt;
            st_r <= st_nxt;
        end
    end

    assign status = st_r;
endmodule

// ===== verilog/pic_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - Enable and disable writes set/clear mask bits
// - Level change sets status, per ownership/direction
// - Interrupt when status bit and mask both set
// - Status read returns bits, then clears all but changes in the read cycle
// - Registers 32 bits, same bit per line
// - Undefined bits ignore writes, read zero
// - Two controllers at two bases, each with its own line map
// - Pin level read shows real pins after reset
// - Status cleared by reset, records later changes
// - Owner set hands line to controller
// - Owned line gives its peripheral zero
// - Owner clear returns line to peripheral
// - Owner status shows ownership, updated each write
// - Drive set turns driver on
// - Drive setting stored even when peripheral-owned
// - Drive and value status reset to zero
// - Controller A peripheral line map
// - Controller B peripheral line map
// - Drive clear turns driver off
// - Stored value drives owned, enabled lines only
// - Pin level always shows physical pin
// - Mask clear keeps change detection running
module pic_top
    import pic_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [31:0] pioAPinIn, // A pin levels
    input wire logic [31:0] pioAPerOut, // A peripheral values
    input wire logic [31:0] pioAPerOe, // A peripheral enables
    output logic [31:0] pioAPinOut, // A pin output values
    output logic [31:0] pioAPinOe, // A pin driver enables
    output logic [31:0] pioAPerIn, // A peripheral inputs
    output logic pioAIrq, // A interrupt, high
    input wire logic [31:0] pioBPinIn, // B pin levels
    input wire logic [31:0] pioBPerOut, // B peripheral values
    input wire logic [31:0] pioBPerOe, // B peripheral enables
    output logic [31:0] pioBPinOut, // B pin output values
    output logic [31:0] pioBPinOe, // B pin driver enables
    output logic [31:0] pioBPerIn, // B peripheral inputs
    output logic pioBIrq // B interrupt, high
);
    // ****************
    // Declarations
    // ****************
    pic_wst_e wst_r, wst_nxt;
    pic_rst_e rst_r, rst_nxt;
    logic awGot_r, awGot_nxt, wGot_r, wGot_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] wDec, rDec, rdClr, irq_r, irq_nxt;
    logic [7:0] wOff, rOff;
    logic wSel, wExec;
    logic [31:0] wBits;
    logic [1:0][31:0] own_r, own_nxt, drv_r, drv_nxt;
    logic [1:0][31:0] oVal_r, oVal_nxt, mask_r, mask_nxt;
    logic [31:0] pinInV [2];
    logic [31:0] perOutV [2];
    logic [31:0] perOeV [2];
    logic [31:0] pinOutV [2];
    logic [31:0] pinOeV [2];
    logic [31:0] perInV [2];
    logic [31:0] evtV [2];
    logic [31:0] stV [2];

    // ****************
    // Decoding
    // ****************
    // Result is {hit, controller}
    function automatic logic [1:0] ctlDec(input logic [31:0] a);
        if (a[31:DEC_LSB] == BASE_A[31:DEC_LSB]) begin
            ctlDec = 2'h2;
        end else if (a[31:DEC_LSB] == BASE_B[31:DEC_LSB]) begin
            ctlDec = 2'h3;
        end else begin
            ctlDec = 2'h0;
        end
    endfunction

    function automatic logic [31:0] strbMask(input logic [3:0] s);
        strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    assign wDec = ctlDec(awaddr_r);
    assign wSel = wDec[0];
    assign wOff = {awaddr_r[7:2], 2'h0};
    assign wExec = (wst_r == WS_EXEC) && wDec[1];
    // Bits of lines that do not exist never reach state
    assign wBits = wdata_r & strbMask(wstrb_r) & DEF_MASK[wSel];

    // ****************
    // Write channel
    // ****************
    always_comb begin
        wst_nxt = wst_r;
        awGot_nxt = awGot_r;
        wGot_nxt = wGot_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        unique case (wst_r)
            WS_IDLE: begin
                if (s_axi_awvalid && awready_r) begin
                    awGot_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                    awready_nxt = 1'b0;
                end
                if (s_axi_wvalid && wready_r) begin
                    wGot_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                    wready_nxt = 1'b0;
                end
                if (awGot_nxt && wGot_nxt) begin
                    wst_nxt = WS_EXEC;
                end
            end
            WS_EXEC: begin
                wst_nxt = WS_RESP;
                bvalid_nxt = 1'b1;
                bresp_nxt = wDec[1] ? RESP_OKAY : RESP_DECERR;
            end
            WS_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = WS_IDLE;
                    bvalid_nxt = 1'b0;
                    awGot_nxt = 1'b0;
                    wGot_nxt = 1'b0;
                    awready_nxt = 1'b1;
                    wready_nxt = 1'b1;
                end
            end
            default: begin
                wst_nxt = WS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wst_r <= WS_IDLE;
            awGot_r <= 1'b0;
            wGot_r <= 1'b0;
            awaddr_r <= RST_ZERO;
            wdata_r <= RST_ZERO;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            wst_r <= wst_nxt;
            awGot_r <= awGot_nxt;
            wGot_r <= wGot_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ****************
    // Controller state
    // ****************
    always_comb begin
        own_nxt = own_r;
        drv_nxt = drv_r;
        oVal_nxt = oVal_r;
        mask_nxt = mask_r;
        if (wExec) begin
            unique case (wOff)
                OFF_OWN_SET: own_nxt[wSel] = own_r[wSel] | wBits;
                OFF_OWN_CLR: own_nxt[wSel] = own_r[wSel] & ~wBits;
                OFF_DRV_SET: drv_nxt[wSel] = drv_r[wSel] | wBits;
                OFF_DRV_CLR: drv_nxt[wSel] = drv_r[wSel] & ~wBits;
                OFF_VAL_SET: oVal_nxt[wSel] = oVal_r[wSel] | wBits;
                OFF_VAL_CLR: oVal_nxt[wSel] = oVal_r[wSel] & ~wBits;
                OFF_IRQ_SET: mask_nxt[wSel] = mask_r[wSel] | wBits;
                OFF_IRQ_CLR: mask_nxt[wSel] = mask_r[wSel] & ~wBits;
                default: ;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            irq_nxt[i] = |(stV[i] & mask_r[i]);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // Lines start owned by the controller as inputs
            own_r <= DEF_MASK;
            drv_r <= {RST_ZERO, RST_ZERO};
            oVal_r <= {RST_ZERO, RST_ZERO};
            mask_r <= {RST_ZERO, RST_ZERO};
            irq_r <= 2'h0;
        end else begin
            own_r <= own_nxt;
            drv_r <= drv_nxt;
            oVal_r <= oVal_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************
    // Read channel
    // ****************
    always_comb begin
        rst_nxt = rst_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        rdClr = 2'h0;
        rDec = ctlDec(s_axi_araddr);
        rOff = {s_axi_araddr[7:2], 2'h0};
        unique case (rst_r)
            RS_IDLE: begin
                if (s_axi_arvalid) begin
                    rst_nxt = RS_RESP;
                    arready_nxt = 1'b0;
                    rvalid_nxt = 1'b1;
                    rresp_nxt = rDec[1] ? RESP_OKAY : RESP_DECERR;
                    rdata_nxt = RST_ZERO;
                    if (rDec[1]) begin
                        unique case (rOff)
                            OFF_OWN_ST: rdata_nxt = own_r[rDec[0]];
                            OFF_DRV_ST: rdata_nxt = drv_r[rDec[0]];
                            OFF_VAL_ST: rdata_nxt = oVal_r[rDec[0]];
                            // Live pins, so valid straight out of reset
                            OFF_PIN: rdata_nxt = pinInV[rDec[0]] & DEF_MASK[rDec[0]];
                            OFF_IRQ_ST: rdata_nxt = mask_r[rDec[0]];
                            OFF_CHG_ST: begin
                                rdata_nxt = stV[rDec[0]];
                                rdClr[rDec[0]] = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
            end
            RS_RESP: begin
                if (s_axi_rready) begin
                    rst_nxt = RS_IDLE;
                    arready_nxt = 1'b1;
                    rvalid_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_r <= RS_IDLE;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= RST_ZERO;
            rresp_r <= RESP_OKAY;
        end else begin
            rst_r <= rst_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ****************
    // Per-controller pin logic
    // ****************
    assign pinInV[0] = pioAPinIn;
    assign pinInV[1] = pioBPinIn;
    assign perOutV[0] = pioAPerOut;
    assign perOutV[1] = pioBPerOut;
    assign perOeV[0] = pioAPerOe;
    assign perOeV[1] = pioBPerOe;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ctl
            pic_pin_mux #(
                .DEF(DEF_MASK[gi]),
                .PER(PER_MASK[gi])
            ) u_mux (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .own(own_r[gi]),
                .drv(drv_r[gi]),
                .oVal(oVal_r[gi]),
                .pinIn(pinInV[gi]),
                .perOut(perOutV[gi]),
                .perOe(perOeV[gi]),
                .pinOut(pinOutV[gi]),
                .pinOe(pinOeV[gi]),
                .perIn(perInV[gi])
            );
            pic_chg_det #(
                .DEF(DEF_MASK[gi])
            ) u_det (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .own(own_r[gi]),
                .drv(drv_r[gi]),
                .oVal(oVal_r[gi]),
                .pinIn(pinInV[gi]),
                .rdClr(rdClr[gi]),
                .evt(evtV[gi]),
                .status(stV[gi])
            );
        end
    endgenerate

    assign pioAPinOut = pinOutV[0];
    assign pioAPinOe = pinOeV[0];
    assign pioAPerIn = perInV[0];
    assign pioBPinOut = pinOutV[1];
    assign pioBPinOe = pinOeV[1];
    assign pioBPerIn = perInV[1];
    assign pioAIrq = irq_r[0];
    assign pioBIrq = irq_r[1];
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ****************
    // Checks on controller A
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic wA, rA;
    assign wA = wExec && !wSel;
    assign rA = (rst_r == RS_IDLE) && s_axi_arvalid && (rDec == 2'h2);

    a_own_set: assert property (
        wA && wOff == OFF_OWN_SET |=> (own_r[0] & $past(wBits)) == $past(wBits)
    ) else $error("Owner set bit not taken");
    a_own_clear: assert property (
        wA && wOff == OFF_OWN_CLR |=> (own_r[0] & $past(wBits)) == 32'h0
    ) else $error("Owner clear bit not taken");
    a_own_hold: assert property (
        !wExec |=> $stable(own_r)
    ) else $error("Ownership changed without a write");
    a_drv_set: assert property (
        wA && wOff == OFF_DRV_SET |=> (drv_r[0] & $past(wBits)) == $past(wBits)
    ) else $error("Drive set bit not stored");
    a_drv_clear: assert property (
        wA && wOff == OFF_DRV_CLR |=> (drv_r[0] & $past(wBits)) == 32'h0
    ) else $error("Drive clear bit not taken");
    a_undef_zero: assert property (
        ((own_r[0] | drv_r[0] | oVal_r[0] | mask_r[0]) & ~DEF_MASK[0]) == 32'h0
    ) else $error("Undefined line bit set");
    a_per_in_low: assert property (
        ##1 (perInV[0] & $past(own_r[0])) == 32'h0
    ) else $error("Owned line leaks to peripheral");
    a_pin_drive: assert property (
        ##1 (pinOutV[0] & $past(own_r[0]) & $past(drv_r[0]))
            == ($past(oVal_r[0]) & $past(own_r[0]) & $past(drv_r[0]))
    ) else $error("Owned pin not at stored value");
    a_irq_gate: assert property (
        |(stV[0] & mask_r[0]) |=> pioAIrq
    ) else $error("Interrupt not raised");
    a_isr_read: assert property (
        rA && rOff == OFF_CHG_ST |=> s_axi_rdata == $past(stV[0])
            && (stV[0] & ~$past(evtV[0])) == 32'h0
    ) else $error("Change status read wrong");
    a_evt_kept: assert property (
        |evtV[0] |=> (stV[0] & $past(evtV[0])) == $past(evtV[0])
    ) else $error("Level change lost");
    a_mask_only: assert property (
        wA && wOff == OFF_IRQ_CLR && !rdClr[0] |=> (stV[0] & $past(stV[0])) == $past(stV[0])
    ) else $error("Mask clear touched status");
    a_pin_read: assert property (
        rA && rOff == OFF_PIN |=> s_axi_rdata == ($past(pinInV[0]) & DEF_MASK[0])
    ) else $error("Pin level read wrong");
endmodule

// ===== tb/pic_far_side.sv
`timescale 1ns/1ps
module pic_far_side (
    input wire logic [31:0] pinOut, // Value offered by the block
    input wire logic [31:0] pinOe, // Driver enables of the block
    input wire logic [31:0] ext, // Board level of undriven pads
    output logic [31:0] pinIn // Resolved pad level
);
    // Released pads take the board level, never the stale driven value
    assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import pic_pkg::*;
    logic clk_sys, rstn, awValid, wValid, bReady, arValid, rReady;
    logic awReady, wReady, bValid, arReady, rValid, irqA, irqB;
    logic [1:0] bResp, rResp, resp;
    logic [31:0] awAddr, wData, arAddr, rData, rdVal, extA, extB, perOutA, perOeA;
    logic [31:0] perOutB, perOeB;
    logic [3:0] wStrb;
    logic [31:0] pinOutA, pinOeA, perInA, pinInA, pinOutB, pinOeB, perInB, pinInB;
    int failCount, samplesChecked, cyc;
    pic_top uut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pioAPinIn(pinInA),
        .pioAPerOut(perOutA), .pioAPerOe(perOeA), .pioAPinOut(pinOutA), .pioAPinOe(pinOeA),
        .pioAPerIn(perInA), .pioAIrq(irqA), .pioBPinIn(pinInB), .pioBPerOut(perOutB),
        .pioBPerOe(perOeB), .pioBPinOut(pinOutB), .pioBPinOe(pinOeB), .pioBPerIn(perInB),
        .pioBIrq(irqB));
    pic_far_side padA (.pinOut(pinOutA), .pinOe(pinOeA), .ext(extA), .pinIn(pinInA));
    pic_far_side padB (.pinOut(pinOutB), .pinOe(pinOeB), .ext(extB), .pinIn(pinInB));
    // ****************
    // Bus and compare helpers
    // ****************
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            failCount++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic axW(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        resp = bResp;
        bReady <= 1'b0;
    endtask
    task automatic axR(input logic [31:0] a);
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        rdVal = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input string nm, input logic [31:0] e);
        axR(a);
        chk(nm, e, rdVal);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic tReset();
        rd(BASE_A + OFF_OWN_ST, "ownA", DEF_MASK[0]);
        rd(BASE_A + OFF_DRV_ST, "drvA", RST_ZERO);
        rd(BASE_A + OFF_VAL_ST, "valA", RST_ZERO);
        rd(BASE_A + OFF_PIN, "pinA", extA & DEF_MASK[0]);
        rd(BASE_B + OFF_PIN, "pinB", extB & DEF_MASK[1]);
        extB <= extB ^ 32'h4;
        idle(4);
        rd(BASE_B + OFF_CHG_ST, "chgB", 32'h4);
        chk("irqB", 32'h0, irqB);
        $display("reset test done");
    endtask
    task automatic tOwn();
        axW(BASE_A + OFF_OWN_CLR, 32'hffffffff);
        rd(BASE_A + OFF_OWN_ST, "ownA", RST_ZERO);
        axW(BASE_A + OFF_OWN_SET, 32'h1);
        rd(BASE_A + OFF_OWN_ST, "ownA", 32'h1);
        idle(2);
        chk("perInA", 32'h100, perInA & 32'h101);
        axW(BASE_B + OFF_OWN_CLR, 32'hffffffff);
        rd(BASE_B + OFF_OWN_ST, "ownB", RST_ZERO);
        chk("pinOeB", 32'h40 & PER_MASK[1], pinOeB);
        chk("pinOutB", 32'h40 & PER_MASK[1], pinOutB);
        chk("perInB", (extB | 32'h40) & PER_MASK[1], perInB);
        $display("ownership test done");
    endtask
    task automatic tDrive();
        axW(BASE_A + OFF_DRV_SET, 32'h101);
        axW(BASE_A + OFF_VAL_SET, 32'h1);
        rd(BASE_A + OFF_DRV_ST, "drvA", 32'h101);
        rd(BASE_A + OFF_VAL_ST, "valA", 32'h1);
        chk("pinOeA", 32'h101, pinOeA);
        chk("pinOutA", 32'h101, pinOutA);
        axW(BASE_A + OFF_VAL_CLR, 32'h1);
        rd(BASE_A + OFF_PIN, "pinA", ((extA & ~32'h101) | 32'h100) & DEF_MASK[0]);
        axW(BASE_A + OFF_DRV_CLR, 32'h1);
        idle(2);
        chk("pinOeA", 32'h100, pinOeA);
        $display("drive test done");
    endtask
    task automatic tIrq();
        axR(BASE_A + OFF_CHG_ST);
        axW(BASE_A + OFF_IRQ_SET, 32'h10);
        rd(BASE_A + OFF_IRQ_ST, "maskA", 32'h10);
        extA <= extA ^ 32'h10;
        idle(4);
        chk("irqA", 32'h1, irqA);
        rd(BASE_A + OFF_CHG_ST, "chgA", 32'h10);
        rd(BASE_A + OFF_CHG_ST, "chgA", RST_ZERO);
        chk("irqA", 32'h0, irqA);
        axW(BASE_A + OFF_IRQ_CLR, 32'h10);
        extA <= extA ^ 32'h10;
        idle(4);
        chk("irqA", 32'h0, irqA);
        rd(BASE_A + OFF_CHG_ST, "chgA", 32'h10);
        $display("interrupt test done");
    endtask
    task automatic tMap();
        axR(32'h00001000);
        chk("rresp", RESP_DECERR, resp);
        axW(BASE_A + 32'h100, 32'h1);
        chk("bresp", RESP_DECERR, resp);
        rd(BASE_A + 32'hc, "reserved", RST_ZERO);
        axW(BASE_A + OFF_OWN_SET, 32'hffffffff);
        rd(BASE_A + OFF_OWN_ST, "ownA", DEF_MASK[0]);
        // Byte strobes limit a clear to the second byte
        wStrb <= 4'h2;
        axW(BASE_A + OFF_OWN_CLR, 32'hffffffff);
        wStrb <= 4'hf;
        rd(BASE_A + OFF_OWN_ST, "ownA", DEF_MASK[0] & ~32'h0000ff00);
        $display("map test done");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Whole run needs about 130 cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failCount++;
            printVerdict();
        end
    end
    initial begin
        {awValid, wValid, bReady, arValid, rReady} = 5'h0;
        {awAddr, wData, arAddr, cyc, failCount, samplesChecked} = '0;
        extA = 32'h00000a5b;
        extB = 32'h00000123;
        perOutA = 32'h100;
        perOeA = 32'h100;
        perOutB = 32'h40;
        perOeB = 32'h40;
        wStrb = 4'hf;
        rstn = 1'b0;
        idle(5);
        rstn <= 1'b1;
        tReset();
        tOwn();
        tDrive();
        tIrq();
        tMap();
        printVerdict();
    end
endmodule
